// >>> verilog/t16c_pkg.sv
// t16c_pkg: register map, field positions and reset values of the
// sixteen_bit_timer control block.
// assumes: 8-bit register port, one 25 MHz clock.
package t16c_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] T16C_ADDR_CTRL   = 8'h02;
  localparam logic [7:0] T16C_ADDR_RLD_LO = 8'h10;
  localparam logic [7:0] T16C_ADDR_RLD_HI = 8'h11;
  localparam logic [7:0] T16C_ADDR_CAP_LO = 8'h12;
  localparam logic [7:0] T16C_ADDR_CAP_HI = 8'h13;
  localparam logic [7:0] T16C_ADDR_STAT   = 8'h14;
  localparam logic [7:0] T16C_ADDR_MASK   = 8'h15;

  // ----------------------------------------------------------------
  // timer16_control fields
  // ----------------------------------------------------------------
  localparam int T16C_CTL_OUTSEL = 0;
  localparam int T16C_CTL_TMO_EN = 1;
  localparam int T16C_CTL_CAP_EN = 2;
  localparam int T16C_CTL_FLAG   = 5;
  localparam int T16C_CTL_STYLE  = 6;
  localparam int T16C_CTL_RUN    = 7;

  // status / mask fields
  localparam int T16C_ST_TMO = 0;
  localparam int T16C_ST_CAP = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  T16C_CTRL_RST = 8'h00;
  localparam logic [15:0] T16C_RLD_RST  = 16'hFFFF;
  localparam logic [15:0] T16C_CNT_RST  = 16'h0000;
  localparam logic [1:0]  T16C_ST_RST   = 2'h0;
  localparam logic [7:0]  T16C_RD_ZERO  = 8'h00;
  localparam logic [2:0]  T16C_SYNC_RST = 3'h0;

endpackage

// >>> verilog/t16c_counter.sv
// t16c_counter: 16-bit down counter with reload and terminal-count pulse.
// assumes: run, restart and reload come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module t16c_counter
  import t16c_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // control
  input  wire logic        i_run,
  input  wire logic        i_restart,
  input  wire logic [15:0] i_reload,
  // status
  output logic      [15:0] o_count,
  output logic             o_tc
);

  typedef struct packed {
    logic [15:0] count;
    logic        tc;
  } t16c_cnt_state_t;

  t16c_cnt_state_t s_r;
  t16c_cnt_state_t s_nxt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt    = s_r;
    s_nxt.tc = 1'b0;
    if (!i_run || i_restart) begin
      // idle counter sits preloaded so a start counts a full period
      s_nxt.count = i_reload;
    end else if (s_r.count == T16C_CNT_RST) begin
      s_nxt.tc    = 1'b1;
      s_nxt.count = i_reload;
    end else begin
      s_nxt.count = s_r.count - 16'h0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '{count: T16C_CNT_RST, tc: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_count = s_r.count;
  assign o_tc    = s_r.tc;

endmodule // t16c_counter
`default_nettype wire

// >>> verilog/t16c_timer_control.sv
// t16c_timer_control: control register logic of the sixteen_bit_timer,
// with reload, capture, sticky interrupt status and pin routing.
// assumes: plain register port with read data one cycle after i_rd,
// i_demod_in is an asynchronous pin, other inputs share i_clk.
//
// Function
// - select bit puts wide_counter_output on shared_port_pin when set.
// - timeout interrupt enable gates the timeout request; reset clears it.
// - capture interrupt enable gates the capture request; reset clears it.
// - timeout flag sets on timeout, reset clears, write 1 clears it.
// - transmit: style 0 repeats modulo-N, style 1 stops after one pass.
// - demodulator: style 0 responds to input edges, style 1 ignores them.
`timescale 1ns/1ps
`default_nettype none
module t16c_timer_control
  import t16c_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // operating mode and pins
  input  wire logic       i_demod_mode,
  input  wire logic       i_demod_in,
  input  wire logic       i_port_out_data,
  output logic            o_shared_port_pin,
  // interrupt
  output logic            o_irq
);

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] reload;
    logic [15:0] capture;
    logic [1:0]  stat;
    logic [1:0]  mask;
    logic [2:0]  sync;
    logic        pin_lvl;
    logic        wco;
    logic        pin_out;
    logic        irq;
    logic [7:0]  rdata;
  } t16c_state_t;

  t16c_state_t s_r;
  t16c_state_t s_nxt;

  logic [15:0] cnt_count;
  logic        cnt_tc;
  logic        edge_ok;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  t16c_counter u_counter (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_run     (s_r.ctrl[T16C_CTL_RUN]),
    .i_restart (edge_ok),
    .i_reload  (s_r.reload),
    .o_count   (cnt_count),
    .o_tc      (cnt_tc)
  );

  // ----------------------------------------------------------------
  // edge recognition
  // ----------------------------------------------------------------
  // a pin change counts only once the second and third stages agree
  logic pin_edge;
  always_comb begin
    pin_edge = (s_r.sync[1] == s_r.sync[2]) && (s_r.sync[2] != s_r.pin_lvl);
    edge_ok  = pin_edge && i_demod_mode && s_r.ctrl[T16C_CTL_RUN]
               && !s_r.ctrl[T16C_CTL_STYLE];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic       wr_ctrl;
  logic       tmo_evt;
  logic [1:0] gate;

  always_comb begin
    s_nxt   = s_r;
    wr_ctrl = i_wr && (i_addr == T16C_ADDR_CTRL);
    // timeouts only count while running; mode switch is left to software
    tmo_evt = cnt_tc && s_r.ctrl[T16C_CTL_RUN];

    s_nxt.sync = {s_r.sync[1:0], i_demod_in};
    if (s_r.sync[1] == s_r.sync[2]) begin
      s_nxt.pin_lvl = s_r.sync[2];
    end

    if (edge_ok) begin
      s_nxt.capture = cnt_count;
    end

    // control register: flag bit is write-one-to-clear, not stored
    if (wr_ctrl) begin
      s_nxt.ctrl = i_wdata;
      s_nxt.ctrl[T16C_CTL_RUN] = i_wdata[T16C_CTL_RUN];
      s_nxt.ctrl[T16C_CTL_FLAG] = s_r.ctrl[T16C_CTL_FLAG]
                                  && !i_wdata[T16C_CTL_FLAG];
    end
    if (tmo_evt) begin
      // set beats a clearing write in the same cycle
      s_nxt.ctrl[T16C_CTL_FLAG] = 1'b1;
      if (!i_demod_mode && s_r.ctrl[T16C_CTL_STYLE] && !wr_ctrl) begin
        s_nxt.ctrl[T16C_CTL_RUN] = 1'b0;
      end
      if (!i_demod_mode) begin
        s_nxt.wco = !s_r.wco;
      end
    end

    if (i_wr && (i_addr == T16C_ADDR_RLD_LO)) begin
      s_nxt.reload[7:0] = i_wdata;
    end
    if (i_wr && (i_addr == T16C_ADDR_RLD_HI)) begin
      s_nxt.reload[15:8] = i_wdata;
    end
    if (i_wr && (i_addr == T16C_ADDR_MASK)) begin
      s_nxt.mask = i_wdata[1:0];
    end

    // sticky status: a read clears, an event in that cycle still sets
    if (i_rd && (i_addr == T16C_ADDR_STAT)) begin
      s_nxt.stat = T16C_ST_RST;
    end
    if (tmo_evt) begin
      s_nxt.stat[T16C_ST_TMO] = 1'b1;
    end
    if (edge_ok) begin
      s_nxt.stat[T16C_ST_CAP] = 1'b1;
    end

    gate[T16C_ST_TMO] = s_nxt.ctrl[T16C_CTL_TMO_EN];
    gate[T16C_ST_CAP] = s_nxt.ctrl[T16C_CTL_CAP_EN];
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask & gate);

    s_nxt.pin_out = s_nxt.ctrl[T16C_CTL_OUTSEL] ? s_nxt.wco
                                                : i_port_out_data;

    s_nxt.rdata = T16C_RD_ZERO;
    if (i_rd) begin
      case (i_addr)
        T16C_ADDR_CTRL:   s_nxt.rdata = s_r.ctrl;
        T16C_ADDR_RLD_LO: s_nxt.rdata = s_r.reload[7:0];
        T16C_ADDR_RLD_HI: s_nxt.rdata = s_r.reload[15:8];
        T16C_ADDR_CAP_LO: s_nxt.rdata = s_r.capture[7:0];
        T16C_ADDR_CAP_HI: s_nxt.rdata = s_r.capture[15:8];
        T16C_ADDR_STAT:   s_nxt.rdata = {6'h00, s_r.stat};
        T16C_ADDR_MASK:   s_nxt.rdata = {6'h00, s_r.mask};
        default:          s_nxt.rdata = T16C_RD_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '{ctrl: T16C_CTRL_RST, reload: T16C_RLD_RST,
               capture: T16C_CNT_RST, stat: T16C_ST_RST,
               mask: T16C_ST_RST, sync: T16C_SYNC_RST,
               pin_lvl: 1'b0, wco: 1'b0, pin_out: 1'b0,
               irq: 1'b0, rdata: T16C_RD_ZERO};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata           = s_r.rdata;
  assign o_shared_port_pin = s_r.pin_out;
  assign o_irq             = s_r.irq;

endmodule // t16c_timer_control
`default_nettype wire

// >>> tb/t16c_timer_control_sva.sv
// t16c_sva: port checks for t16c_timer_control.
// assumes: bound to the top module; one clock, async high reset.
`timescale 1ns/1ps
`default_nettype none
module t16c_sva
  import t16c_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_port_out_data,
  input wire logic       o_shared_port_pin,
  input wire logic       o_irq
);
  logic [1:0] en_r, msk_r;
  logic       sel_r, ran_r;
  wire logic  wr_ctl = i_wr && i_addr == T16C_ADDR_CTRL;
  wire logic  rd_ctl = i_rd && i_addr == T16C_ADDR_CTRL;
  wire logic  gate   = |(en_r & msk_r);
  // shadow of what software wrote, since the design's copy is hidden
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {en_r, msk_r, sel_r, ran_r} <= 6'h00;
    end else begin
      if (wr_ctl) begin
        {en_r, sel_r} <= i_wdata[2:0];
        ran_r <= ran_r | i_wdata[7];
      end
      if (i_wr && i_addr == T16C_ADDR_MASK) begin
        msk_r <= i_wdata[1:0];
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == T16C_RD_ZERO)
    else $error("read data not zero outside a read");
  chk_unmapped_zero: assert property ($past(i_rd && i_addr > T16C_ADDR_MASK)
    |-> o_rdata == T16C_RD_ZERO) else $error("unmapped read not zero");
  chk_pin_port: assert property (
    !sel_r && !$past(sel_r) && !$past(i_rst)
    |-> o_shared_port_pin == $past(i_port_out_data))
    else $error("pin does not follow port data");
  chk_irq_gate: assert property (
    o_irq |-> gate || $past(gate))
    else $error("interrupt without enable and mask");
  chk_flag_quiet: assert property (
    $past(rd_ctl) && !ran_r |-> !o_rdata[T16C_CTL_FLAG])
    else $error("timeout flag set before any run");
  chk_ctl_readback: assert property (
    wr_ctl && !i_wdata[T16C_CTL_STYLE] ##1 rd_ctl |-> ##1
    {o_rdata[7], o_rdata[4:0]} ==
    {$past(i_wdata[7], 2), $past(i_wdata[4:0], 2)})
    else $error("control readback differs");
  chk_mask_readback: assert property (
    i_wr && i_addr == T16C_ADDR_MASK ##1 i_rd && i_addr == T16C_ADDR_MASK
    |-> ##1 o_rdata == {6'h00, $past(i_wdata[1:0], 2)})
    else $error("mask readback differs");
  cov_irq: cover property (o_irq);
  cov_pin_rise: cover property ($rose(o_shared_port_pin));
  cov_wr_rd: cover property (wr_ctl ##1 rd_ctl);
endmodule // t16c_sva
bind t16c_timer_control t16c_sva u_t16c_sva (.i_clk, .i_rst, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .i_port_out_data, .o_shared_port_pin,
  .o_irq);
`default_nettype wire

// >>> tb/testbench.sv
// testbench: register-level tests of t16c_timer_control.
// assumes: one 25 MHz clock; registers at the package offsets.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import t16c_pkg::*;
;
  logic       i_clk, i_rst, i_wr, i_rd, i_demod_mode, i_demod_in;
  logic       i_port_out_data, o_shared_port_pin, o_irq, p;
  logic [7:0] i_addr, i_wdata, o_rdata;
  int         miscompares, cmp_count;
  t16c_timer_control u_t16c_timer_control (.i_clk, .i_rst, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_demod_mode, .i_demod_in,
    .i_port_out_data, .o_shared_port_pin, .o_irq);
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic test_done;
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // compares at a negedge, then realigns to the next rising edge
  task automatic chk(input string n, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk($sformatf("reg %h", a), o_rdata, e);
  endtask
  task automatic pin(input string n, input logic e);
    @(posedge i_clk);
    @(negedge i_clk);
    chk(n, {7'h00, n == "irq" ? o_irq : o_shared_port_pin}, {7'h00, e});
  endtask
  initial begin
    repeat (2000) @(posedge i_clk);
    miscompares++;
    test_done;
  end
  initial begin
    {i_rst, i_wr, i_rd, i_addr, i_wdata} = {3'h4, 16'h0000};
    {i_demod_mode, i_demod_in, i_port_out_data} = 3'h0;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rd(T16C_ADDR_CTRL, T16C_CTRL_RST);
    rd(8'h20, T16C_RD_ZERO);
    rd(T16C_ADDR_RLD_HI, 8'hFF);
    i_port_out_data <= 1'b1;
    pin("pin", 1'b1);
    wr(T16C_ADDR_RLD_LO, 8'h03);
    rd(T16C_ADDR_RLD_LO, 8'h03);
    wr(T16C_ADDR_RLD_HI, 8'h00);
    wr(T16C_ADDR_CTRL, 8'h98);
    rd(T16C_ADDR_CTRL, 8'h98);
    repeat (8) @(posedge i_clk);
    rd(T16C_ADDR_CTRL, 8'hB8);
    wr(T16C_ADDR_CTRL, 8'h00);
    rd(T16C_ADDR_CTRL, 8'h20);
    wr(T16C_ADDR_CTRL, 8'h20);
    rd(T16C_ADDR_CTRL, 8'h00);
    wr(T16C_ADDR_CTRL, 8'hC0);
    repeat (8) @(posedge i_clk);
    rd(T16C_ADDR_CTRL, 8'h60);
    wr(T16C_ADDR_MASK, 8'h01);
    rd(T16C_ADDR_MASK, 8'h01);
    pin("irq", 1'b0);
    wr(T16C_ADDR_CTRL, 8'h42);
    pin("irq", 1'b1);
    rd(T16C_ADDR_STAT, 8'h01);
    pin("irq", 1'b0);
    wr(T16C_ADDR_CTRL, 8'h81);
    repeat (2) @(posedge i_clk);
    @(negedge i_clk) p = o_shared_port_pin;
    repeat (4) @(negedge i_clk);
    chk("toggle", {7'h00, o_shared_port_pin}, {7'h00, ~p});
    wr(T16C_ADDR_CTRL, 8'h00);
    i_port_out_data <= 1'b0;
    pin("pin", 1'b0);
    i_demod_mode <= 1'b1;
    wr(T16C_ADDR_RLD_LO, 8'hFF);
    rd(T16C_ADDR_RLD_LO, 8'hFF);
    wr(T16C_ADDR_RLD_HI, 8'hFF);
    rd(T16C_ADDR_STAT, 8'h01);
    wr(T16C_ADDR_MASK, 8'h02);
    rd(T16C_ADDR_MASK, 8'h02);
    wr(T16C_ADDR_CTRL, 8'h84);
    i_demod_in <= 1'b1;
    repeat (8) @(posedge i_clk);
    pin("irq", 1'b1);
    rd(T16C_ADDR_STAT, 8'h02);
    rd(T16C_ADDR_CAP_HI, 8'hFF);
    rd(T16C_ADDR_CAP_LO, 8'hFC);
    wr(T16C_ADDR_CTRL, 8'hC4);
    i_demod_in <= 1'b0;
    repeat (8) @(posedge i_clk);
    rd(T16C_ADDR_STAT, 8'h00);
    test_done;
  end
endmodule // testbench
`default_nettype wire
